// *** design/mcf_top.sv ***
// apb command interpreter: value entry, calibration, defaults, format
// assumes apb master on pclk; reading text supplied per token elsewhere
//
// Notes on behaviour
// - decimal or exponent notation gives same value
// - pad short entries with trailing zeros
// - entry also sets zero offset, reference temperature
// - selector picks first or second point
// - second point writes both constants
// - reject values above limit, flag error
// - calibrate only with protection switch unlocked
// - factory restore reloads defaults, now and later; a bus clear in the same cycle leaves range unchanged
// - factory restore keeps address and line frequency
// - save copies current settings to storage
// - format zero: prefix, tagged location
// - format one: bare reading, untagged location
// - formats two, three: whole buffer with locations
// - formats four, five: whole buffer, no locations
// - source selects converter or stored buffer
// - terminator per reading, or once per buffer
// - buffer format on converter: no terminator
// - no wraparound size with high-speed interval
// - format returns to default on reset, clear
// - bad high-speed combination: error, no start
`timescale 1ns/1ns
`include "mcf_params.svh"
module mcf_top import mcf_pkg::*; (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // switch pin and bus clear
    input wire logic cal_unlock_pin,
    input wire logic dev_clear,
    // calibration storage
    output logic nv_cal_we,
    output logic [3:0] nv_cal_range,
    output logic [23:0] nv_cal_high,
    output logic [23:0] nv_cal_low,
    // power-up settings storage
    output logic nv_setup_we,
    output logic [15:0] nv_setup_image,
    // settings driven from the value entry
    output logic [24:0] zero_offset,
    output logic [24:0] ref_temp,
    // data store control
    output logic store_start,
    output logic wraparound_store_size,
    // output token stream
    input wire logic talk_req,
    input wire logic [8:0] buf_count,
    input wire logic out_ready,
    output logic out_valid,
    output mcf_kind_t out_kind,
    output logic [7:0] out_char,
    output logic [8:0] out_loc,
    output logic out_eoi,
    output logic invalid_option_error
);
    // ****************************************
    // state
    // ****************************************
    logic unlock_meta, unlock_s; // switch synchroniser
    logic [23:0] val_mag; // entered magnitude
    logic val_neg; // entered sign
    logic [3:0] val_digits; // digits held so far
    logic pad_busy; // padding in progress
    logic value_valid; // fresh value present
    logic high_pending; // first point taken
    mcf_fmt_t fmt; // output format
    logic src; // 1 = stored source
    logic [3:0] range; // range under calibration
    logic [4:0] bus_addr; // bus address
    logic line_freq; // mains frequency select
    logic [19:0] interval; // store interval, ms
    logic [8:0] size; // store size, 0 = wraparound
    mcf_st_t st, next_st; // stream state
    logic [11:0] bcd; // location digits
    // ****************************************
    // apb decode
    // ****************************************
    logic wr, wr_val, wr_cmd, wr_cfg, wr_sto, wr_stat, mapped;
    mcf_cmd_t cmd;
    logic cal_cmd, cal_ok, cmd_err, cfg_err, sto_err, val_err, err_set;
    logic [15:0] cur_image, fac_image;
    assign pready = !pad_busy;
    assign wr = psel && penable && pwrite && pready;
    assign cmd = mcf_cmd_t'(pwdata[2:0]);
    // address decode
    always_comb begin
        mapped = 1'b1;
        if (paddr == `MCF_A_VALUE) begin
            prdata = {val_neg, 3'h0, val_digits, val_mag};
        end else if (paddr == `MCF_A_CFG) begin
            prdata = {7'h00, line_freq, 3'h0, bus_addr, 4'h0, range,
                3'h0, src, 1'h0, fmt};
        end else if (paddr == `MCF_A_STORE) begin
            prdata = {3'h0, size, interval};
        end else if (paddr == `MCF_A_STATUS) begin
            prdata = {28'h0000000, pad_busy, high_pending, value_valid,
                invalid_option_error};
        end else if (paddr == `MCF_A_CMD) begin
            prdata = 32'h00000000;
        end else begin
            // unmapped: zero data, error answer
            prdata = 32'h00000000;
            mapped = 1'b0;
        end
    end
    assign pslverr = psel && penable && !mapped;
    assign wr_val = wr && paddr == `MCF_A_VALUE;
    assign wr_cmd = wr && paddr == `MCF_A_CMD;
    assign wr_cfg = wr && paddr == `MCF_A_CFG;
    assign wr_sto = wr && paddr == `MCF_A_STORE;
    assign wr_stat = wr && paddr == `MCF_A_STATUS;
    // ****************************************
    // error checks
    // ****************************************
    // selector decode
    assign cal_cmd = cmd == cal_high_point || cmd == cal_low_point;
    assign cal_ok = unlock_s && value_valid &&
        val_mag <= `MCF_CAL_LIMIT;
    always_comb begin
        cmd_err = 1'b0;
        if (wr_cmd) begin
            if (pwdata[2:0] > 3'h5) begin
                cmd_err = 1'b1;
            end else if (cal_cmd && !cal_ok) begin
                cmd_err = 1'b1;
            end else if (cmd == cal_low_point && !high_pending) begin
                cmd_err = 1'b1;
            end else if (!cal_cmd && cmd <= cmd_ref_temp) begin
                cmd_err = !value_valid;
            end
        end
    end
    assign cfg_err = wr_cfg && pwdata[2:0] > 3'h5;
    assign sto_err = wr_sto && pwdata[`MCF_STORE_GO] &&
        pwdata[28:20] == 9'h000 && pwdata[19:0] != 20'h00000 &&
        pwdata[19:0] <= `MCF_HS_MAX_MS;
    assign val_err = wr_val && (pwdata[27:24] == 4'h0 ||
        pwdata[27:24] > `MCF_FULL_DIGITS);
    assign err_set = cmd_err || cfg_err || sto_err || val_err;
    // sticky error, set beats a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            invalid_option_error <= 1'b0;
        end else if (err_set) begin
            invalid_option_error <= 1'b1;
        end else if (wr_stat && pwdata[0]) begin
            invalid_option_error <= 1'b0;
        end
    end
    // two-flop switch synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_meta <= 1'b0;
            unlock_s <= 1'b0;
        end else begin
            unlock_meta <= cal_unlock_pin;
            unlock_s <= unlock_meta;
        end
    end
    // ****************************************
    // value entry
    // ****************************************
    // mantissa padded to full precision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_mag <= 24'h000000;
            val_neg <= 1'b0;
            val_digits <= 4'h0;
            pad_busy <= 1'b0;
            value_valid <= 1'b0;
        end else if (wr_val && !val_err) begin
            val_mag <= pwdata[23:0];
            val_neg <= pwdata[`MCF_VAL_NEG];
            val_digits <= pwdata[27:24];
            pad_busy <= 1'b1;
            value_valid <= 1'b0;
        end else if (pad_busy) begin
            // one trailing zero per cycle
            if (val_digits < `MCF_FULL_DIGITS) begin
                val_mag <= 24'((val_mag << 3) + (val_mag << 1));
                val_digits <= val_digits + 4'h1;
            end else begin
                pad_busy <= 1'b0;
                value_valid <= 1'b1;
            end
        end else if (wr_cmd && cal_cmd) begin
            // a calibration uses the value up
            value_valid <= 1'b0;
        end
    end
    // value feeds zero offset and reference
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_offset <= 25'h0000000;
            ref_temp <= 25'h0000000;
        end else if (wr_cmd && !cmd_err && cmd == cmd_zero_offset) begin
            zero_offset <= {val_neg, val_mag};
        end else if (wr_cmd && !cmd_err && cmd == cmd_ref_temp) begin
            ref_temp <= {val_neg, val_mag};
        end else if (wr_cmd && !cmd_err && cmd == factory_restore) begin
            zero_offset <= 25'h0000000;
            ref_temp <= 25'h0000000;
        end
    end
    // ****************************************
    // calibration
    // ****************************************
    // first point held, second writes both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_pending <= 1'b0;
            nv_cal_we <= 1'b0;
            nv_cal_range <= 4'h0;
            nv_cal_high <= 24'h000000;
            nv_cal_low <= 24'h000000;
        end else begin
            nv_cal_we <= 1'b0;
            if (wr_cmd && !cmd_err && cmd == cal_high_point) begin
                nv_cal_high <= val_mag;
                nv_cal_range <= range;
                high_pending <= 1'b1;
            end else if (wr_cmd && !cmd_err && cmd == cal_low_point) begin
                nv_cal_low <= val_mag;
                nv_cal_we <= 1'b1;
                high_pending <= 1'b0;
            end
        end
    end
    // ****************************************
    // settings, defaults and store control
    // ****************************************
    assign cur_image = {2'h0, line_freq, bus_addr, range, src, fmt};
    // factory image keeps address and line setting
    assign fac_image = {2'h0, line_freq, bus_addr, 4'h0, `MCF_SRC_RESET,
        `MCF_FMT_RESET};
    // active settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt <= mcf_fmt_t'(`MCF_FMT_RESET);
            src <= `MCF_SRC_RESET;
            range <= 4'h0;
            bus_addr <= 5'h00;
            line_freq <= 1'b0;
        end else if (dev_clear) begin
            fmt <= mcf_fmt_t'(`MCF_FMT_RESET);
            src <= `MCF_SRC_RESET;
        end else if (wr_cfg) begin
            if (!cfg_err) begin
                fmt <= mcf_fmt_t'(pwdata[2:0]);
            end
            src <= pwdata[`MCF_CFG_SRC];
            range <= pwdata[11:8];
            bus_addr <= pwdata[20:16];
            line_freq <= pwdata[`MCF_CFG_LINE];
        end else if (wr_cmd && cmd == factory_restore) begin
            fmt <= mcf_fmt_t'(`MCF_FMT_RESET);
            src <= `MCF_SRC_RESET;
            range <= 4'h0;
        end
    end
    // power-up image to storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_setup_we <= 1'b0;
            nv_setup_image <= 16'h0000;
        end else begin
            nv_setup_we <= wr_cmd && (cmd == factory_restore ||
                cmd == save_power_up_state);
            if (wr_cmd && cmd == factory_restore) begin
                // factory image used at later power-ups
                nv_setup_image <= fac_image;
            end else if (wr_cmd && cmd == save_power_up_state) begin
                nv_setup_image <= cur_image;
            end
        end
    end
    // store setup and start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interval <= 20'h00000;
            size <= 9'h000;
            store_start <= 1'b0;
        end else begin
            // start only for a permitted combination
            store_start <= wr_sto && pwdata[`MCF_STORE_GO] && !sto_err;
            if (wr_sto) begin
                interval <= pwdata[19:0];
                size <= pwdata[28:20];
            end
        end
    end
    assign wraparound_store_size = size == 9'h000;
    // ****************************************
    // output stream
    // ****************************************
    logic pfx, locs, tag, whole, last, term_on, take, entry_done;
    assign pfx = fmt == single_with_prefix ||
        fmt == buffer_prefix_location || fmt == buffer_prefix_only;
    assign tag = fmt == single_with_prefix ||
        fmt == buffer_prefix_location;
    assign whole = fmt >= buffer_prefix_location;
    // locations only when reading the stored buffer
    assign locs = src && fmt <= buffer_location_only;
    assign last = !whole || !src || out_loc >= buf_count;
    assign term_on = !(whole && !src);
    assign take = out_valid && out_ready;
    assign entry_done = take &&
        (st == st_dig0 || (st == st_read && !locs));
    // next stream state
    always_comb begin
        next_st = st;
        case (st)
            st_idle: begin
                if (talk_req) begin
                    next_st = pfx ? st_prefix : st_read;
                end
            end
            st_prefix: next_st = st_read;
            st_read: begin
                if (locs) begin
                    next_st = st_lcomma;
                end else if (!last) begin
                    next_st = st_sep;
                end else begin
                    next_st = term_on ? st_term : st_idle;
                end
            end
            st_lcomma: next_st = tag ? st_ltag : st_dig2;
            st_ltag: next_st = st_dig2;
            st_dig2: next_st = st_dig1;
            st_dig1: next_st = st_dig0;
            st_dig0: begin
                if (!last) begin
                    next_st = st_sep;
                end else begin
                    next_st = term_on ? st_term : st_idle;
                end
            end
            st_sep: next_st = pfx ? st_prefix : st_read;
            default: next_st = st_idle;
        endcase
    end
    // stream state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= st_idle;
        end else if (st == st_idle || take) begin
            st <= next_st;
        end
    end
    // location counter in binary and three bcd digits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_loc <= 9'h001;
            bcd <= 12'h001;
        end else if (wr_cfg || (st == st_idle && talk_req && whole) ||
            (entry_done && last && whole)) begin
            out_loc <= 9'h001;
            bcd <= 12'h001;
        end else if ((take && st == st_sep) ||
            (entry_done && !whole && src)) begin
            if (!whole && out_loc >= buf_count) begin
                // single stored reads wrap to the first slot
                out_loc <= 9'h001;
                bcd <= 12'h001;
            end else begin
                out_loc <= out_loc + 9'h001;
                if (bcd[3:0] != 4'h9) begin
                    bcd[3:0] <= bcd[3:0] + 4'h1;
                end else if (bcd[7:4] != 4'h9) begin
                    bcd[3:0] <= 4'h0;
                    bcd[7:4] <= bcd[7:4] + 4'h1;
                end else begin
                    bcd[7:0] <= 8'h00;
                    bcd[11:8] <= bcd[11:8] + 4'h1;
                end
            end
        end
    end
    // token kind and literal character
    always_comb begin
        out_kind = kind_char;
        out_char = 8'h00;
        case (st)
            st_prefix: out_kind = kind_prefix;
            st_read: out_kind = kind_reading;
            st_term: out_kind = kind_term;
            st_lcomma: out_char = `MCF_CH_COMMA;
            st_sep: out_char = `MCF_CH_COMMA;
            st_ltag: out_char = `MCF_CH_TAG;
            st_dig2: out_char = `MCF_CH_ZERO | {4'h0, bcd[11:8]};
            st_dig1: out_char = `MCF_CH_ZERO | {4'h0, bcd[7:4]};
            st_dig0: out_char = `MCF_CH_ZERO | {4'h0, bcd[3:0]};
            default: out_char = 8'h00;
        endcase
    end
    assign out_valid = st != st_idle;
    assign out_eoi = st == st_term;
    // ****************************************
    // assertions
    // ****************************************
    a_cal_locked: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cmd && cal_cmd && !unlock_s |=> invalid_option_error && !nv_cal_we)
        else $error("calibration taken while locked");
    a_cal_limit: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cmd && cmd == cal_high_point && val_mag > `MCF_CAL_LIMIT
        |=> invalid_option_error && $stable(nv_cal_high))
        else $error("over-limit calibration value accepted");
    a_cal_write: assert property (@(posedge pclk) disable iff (!presetn)
        nv_cal_we |-> $past(wr_cmd) && $past(high_pending) &&
        !high_pending)
        else $error("constants written without both points");
    a_cal_fresh: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cmd && cal_cmd && !value_valid |=> !nv_cal_we ##1 !nv_cal_we)
        else $error("calibration without fresh value");
    a_pad_full: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(value_valid) |-> val_digits == `MCF_FULL_DIGITS)
        else $error("value marked valid before padding done");
    a_fmt_clear: assert property (@(posedge pclk) disable iff (!presetn)
        dev_clear |=> fmt == mcf_fmt_t'(`MCF_FMT_RESET))
        else $error("format not restored by clear");
    a_hs_reject: assert property (@(posedge pclk) disable iff (!presetn)
        sto_err |=> !store_start && invalid_option_error)
        else $error("forbidden store combination started");
    a_fac_keep: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cmd && cmd == factory_restore && !dev_clear
        |=> $stable(bus_addr) && $stable(line_freq) &&
        nv_setup_we)
        else $error("factory restore disturbed address or line");
    a_no_term: assert property (@(posedge pclk) disable iff (!presetn)
        out_eoi |-> term_on)
        else $error("terminator sent on converter buffer format");
    a_prefix_use: assert property (@(posedge pclk) disable iff (!presetn)
        out_valid && out_kind == kind_prefix |-> pfx)
        else $error("prefix sent in a bare format");
endmodule : mcf_top

// *** common/mcf_params.svh ***
// constants for the meter command interpreter: offsets, fields, limits
// assumes byte addressing on a 32-bit apb bus
`ifndef MCF_PARAMS_SVH
`define MCF_PARAMS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define MCF_A_VALUE 8'h00
`define MCF_A_CMD 8'h04
`define MCF_A_CFG 8'h08
`define MCF_A_STORE 8'h0C
`define MCF_A_STATUS 8'h10
// ****************************************
// fields, limits and reset values
// ****************************************
`define MCF_VAL_NEG 31
`define MCF_CFG_SRC 4
`define MCF_CFG_LINE 24
`define MCF_STORE_GO 31
`define MCF_FULL_DIGITS 4'h7
`define MCF_CAL_LIMIT 24'h2191C0
`define MCF_HS_MAX_MS 20'h00004
`define MCF_FMT_RESET 3'h0
`define MCF_SRC_RESET 1'h0
`define MCF_CH_COMMA 8'h2C
`define MCF_CH_TAG 8'h42
`define MCF_CH_ZERO 8'h30
`endif

// *** common/mcf_pkg.sv ***
// types shared by the meter command interpreter
// assumes nothing beyond a systemverilog compiler
package mcf_pkg;
    // command codes written to the command register
    typedef enum logic [2:0] {cmd_zero_offset, cmd_ref_temp,
        cal_high_point, cal_low_point, factory_restore,
        save_power_up_state} mcf_cmd_t;
    // output data formats
    typedef enum logic [2:0] {single_with_prefix, single_bare,
        buffer_prefix_location, buffer_location_only,
        buffer_prefix_only, buffer_bare} mcf_fmt_t;
    // token kinds on the output stream
    typedef enum logic [1:0] {kind_prefix, kind_reading, kind_char,
        kind_term} mcf_kind_t;
    // output stream states
    typedef enum logic [3:0] {st_idle, st_prefix, st_read, st_lcomma,
        st_ltag, st_dig2, st_dig1, st_dig0, st_sep, st_term} mcf_st_t;
endpackage : mcf_pkg

// *** tb/mcf_sink.sv ***
// far-side model: bus controller taking the output token stream
// assumes tokens are offered by the interpreter on pclk
`timescale 1ns/1ns
module mcf_sink import mcf_pkg::*; (
    // clock and pacing
    input wire logic pclk,
    input wire logic slow,
    // token stream
    input wire logic out_valid,
    input wire mcf_kind_t out_kind,
    input wire logic [7:0] out_char,
    input wire logic out_eoi,
    output logic out_ready
);
    string log_s = ""; // accepted tokens as text
    logic tog = 1'b0; // pacing toggle for stalls
    // stall every other cycle when slow
    always @(posedge pclk) begin
        tog <= ~tog;
    end
    assign out_ready = slow ? tog : 1'b1;
    // record each accepted token
    always @(posedge pclk) begin
        if (out_valid === 1'b1 && out_ready) begin
            case (out_kind)
                kind_prefix: log_s = {log_s, "P"};
                kind_reading: log_s = {log_s, "R"};
                kind_char: log_s = {log_s, string'(out_char)};
                default: log_s = {log_s, (out_eoi === 1'b1) ? "T" : "t"};
            endcase
        end
    end
endmodule : mcf_sink

// *** tb/mcf_top_tb.sv ***
// bench for the meter command interpreter: apb stimulus, self-checking
// assumes mcf_top, mcf_sink and the shared package are compiled first
`timescale 1ns/1ns
`include "mcf_params.svh"
module mcf_top_tb import mcf_pkg::*; ;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, cal_unlock_pin = 1'b0, dev_clear = 1'b0;
    logic talk_req = 1'b0, slow = 1'b0, err;
    logic [7:0] paddr = 8'h00, out_char;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [8:0] buf_count = 9'h002, out_loc;
    logic pready, pslverr, nv_cal_we, nv_setup_we, store_start;
    logic wraparound_store_size, out_valid, out_ready, out_eoi;
    logic invalid_option_error;
    logic [3:0] nv_cal_range;
    logic [23:0] nv_cal_high, nv_cal_low;
    logic [15:0] nv_setup_image;
    logic [24:0] zero_offset, ref_temp;
    mcf_kind_t out_kind;
    int n_mismatch = 0, check_count = 0, n_cal = 0, n_set = 0, n_go = 0;
    mcf_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cal_unlock_pin, .dev_clear,
        .nv_cal_we, .nv_cal_range, .nv_cal_high, .nv_cal_low, .nv_setup_we,
        .nv_setup_image, .zero_offset, .ref_temp, .store_start,
        .wraparound_store_size, .talk_req, .buf_count, .out_ready,
        .out_valid, .out_kind, .out_char, .out_loc, .out_eoi,
        .invalid_option_error);
    mcf_sink sink_u (.pclk, .slow, .out_valid, .out_kind, .out_char,
        .out_eoi, .out_ready);
    // clock and pulse counters
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) begin
        n_cal += int'(nv_cal_we === 1'b1);
        n_set += int'(nv_setup_we === 1'b1);
        n_go += int'(store_start === 1'b1);
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    // one apb transfer, held until pready seen high
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // access phase: pready looked at on rising edges only
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end else begin
            q = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : bus
    task automatic err_is(input logic [31:0] e);
        bus(0, `MCF_A_STATUS, 32'h0);
        chk(32'(q[0]), e);
        bus(1, `MCF_A_STATUS, 32'h1);
    endtask : err_is
    task automatic t_value;
        bus(0, 8'h20, 32'h0);
        chk(32'(err), 32'h1);
        bus(1, `MCF_A_VALUE, 32'h0200_0014);
        bus(0, `MCF_A_VALUE, 32'h0);
        chk(32'(q[23:0]), 32'h001E_8480);
        bus(1, `MCF_A_CMD, 32'h0);
        bus(1, `MCF_A_CMD, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(zero_offset), 32'h001E_8480);
        chk(32'(ref_temp), 32'h001E_8480);
    endtask : t_value
    task automatic t_cal;
        bus(1, `MCF_A_CFG, 32'h0000_0300);
        bus(1, `MCF_A_VALUE, 32'h0100_0002);
        bus(1, `MCF_A_CMD, 32'h2);
        err_is(32'h1);
        cal_unlock_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        bus(1, `MCF_A_VALUE, 32'h0721_91C1);
        bus(1, `MCF_A_CMD, 32'h2);
        err_is(32'h1);
        bus(1, `MCF_A_VALUE, 32'h0100_0002);
        bus(1, `MCF_A_CMD, 32'h2);
        // second point with the value already used up
        bus(1, `MCF_A_CMD, 32'h3);
        err_is(32'h1);
        bus(1, `MCF_A_VALUE, 32'h0100_0000);
        bus(1, `MCF_A_CMD, 32'h3);
        repeat (2) @(posedge pclk);
        chk(32'(n_cal), 32'h1);
        chk(32'(nv_cal_high), 32'h001E_8480);
        chk(32'(nv_cal_low), 32'h0);
        chk(32'(nv_cal_range), 32'h3);
        err_is(32'h0);
    endtask : t_cal
    task automatic t_defaults;
        bus(1, `MCF_A_CFG, 32'h0105_0311);
        bus(1, `MCF_A_CMD, 32'h5);
        repeat (2) @(posedge pclk);
        chk(32'(nv_setup_image), 32'h2539);
        bus(1, `MCF_A_CMD, 32'h4);
        repeat (2) @(posedge pclk);
        chk(32'(n_set), 32'h2);
        chk(32'(nv_setup_image), 32'h2500);
        chk(32'(zero_offset), 32'h0);
        bus(0, `MCF_A_CFG, 32'h0);
        chk(q & 32'h011F_0F17, 32'h0105_0000);
    endtask : t_defaults
    task automatic t_store;
        bus(1, `MCF_A_STORE, 32'h8000_0002);
        repeat (2) @(posedge pclk);
        chk(32'(wraparound_store_size), 32'h1);
        chk(32'(n_go), 32'h0);
        err_is(32'h1);
        bus(1, `MCF_A_STORE, 32'h80A0_0002);
        repeat (2) @(posedge pclk);
        chk(32'(n_go), 32'h1);
    endtask : t_store
    // one talk transfer, stream compared as text
    task automatic xfer(input logic wr, input logic [4:0] c, input string e);
        if (wr)
            bus(1, `MCF_A_CFG, 32'(c));
        sink_u.log_s = "";
        @(posedge pclk);
        talk_req <= 1'b1;
        @(posedge pclk);
        talk_req <= 1'b0;
        repeat (60) @(posedge pclk);
        check_count++;
        if (sink_u.log_s != e) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, sink_u.log_s, e);
            n_mismatch++;
        end
    endtask : xfer
    task automatic t_format;
        slow <= 1'b1;
        xfer(1, 5'h10, "PR,B001T");
        xfer(0, 5'h10, "PR,B002T");
        chk(32'(out_loc), 32'h1);
        xfer(1, 5'h11, "R,001T");
        xfer(1, 5'h12, "PR,B001,PR,B002T");
        xfer(1, 5'h13, "R,001,R,002T");
        xfer(1, 5'h14, "PR,PRT");
        xfer(1, 5'h15, "R,RT");
        xfer(1, 5'h02, "PR");
        xfer(1, 5'h01, "RT");
        bus(1, `MCF_A_CFG, 32'h13);
        dev_clear <= 1'b1;
        @(posedge pclk);
        dev_clear <= 1'b0;
        bus(0, `MCF_A_CFG, 32'h0);
        chk(32'(q[4:0]), 32'h0);
    endtask : t_format
    // reset, scenarios, verdict
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        bus(0, `MCF_A_CFG, 32'h0);
        chk(32'(q[2:0]), 32'(`MCF_FMT_RESET));
        t_value();
        t_cal();
        t_defaults();
        t_store();
        t_format();
        report_and_stop();
    end
endmodule : mcf_top_tb
